// File: src/srmc_pkg.sv
package srmc_pkg;

   // Channel count and serial frame width.
   localparam int N_CH = 5;
   localparam int FRAME_W = 8;
   localparam int CNT_W = 6;

   // System clock rate and power-on wake-up time (longest time, so round down).
   localparam int CLK_HZ = 20_000_000;
   localparam int T_WU_US = 500;
   localparam int WU_CYC = (T_WU_US * (CLK_HZ / 1_000_000)) < 1 ? 1 :
                           T_WU_US * (CLK_HZ / 1_000_000);

   // Register addresses carried in the frame.
   localparam logic [1:0] ADDR_OUT = 2'h0;
   localparam logic [1:0] ADDR_DCR = 2'h1;
   localparam logic [1:0] ADDR_HARDWARE_CONFIG_REGISTER = 2'h2;

   // Field positions and reset values.
   localparam int HW_RST_BIT = 1;
   localparam int HW_STB_BIT = 1;
   localparam int HW_LHI_BIT = 2;
   localparam logic [2:0] SEL_STANDBY = 3'h7;
   localparam logic [4:0] OUT_RST = 5'h00;
   localparam logic [1:0] ADDR_RST = 2'h0;

   // Frame taken from the host: write flag, address, data.
   typedef struct packed {
      logic wr;
      logic [1:0] addr;
      logic [4:0] data;
   } srmc_frame_t;

   // Reply shifted to the host: transfer error flag, address, read data.
   typedef struct packed {
      logic transfer_error_flag;
      logic [1:0] addr;
      logic [4:0] data;
   } srmc_reply_t;

   typedef enum logic [1:0] {
      SRMC_WAKE = 2'b00,
      SRMC_RUN = 2'b01
   } srmc_state_t;

endpackage

// File: src/srmc_spi_shift.sv
`timescale 1ns/1ps
`default_nettype none

module srmc_spi_shift (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic si_i,
   input wire logic [srmc_pkg::FRAME_W-1:0] tx_i,
   output logic [srmc_pkg::FRAME_W-1:0] rx_o,
   output logic done_o,
   output logic err_o,
   output logic so_o,
   output logic so_oe_o
);

   logic sclk_s1, sclk_s2, sclk_s3;
   logic cs_s1, cs_s2, cs_s3;
   logic si_s1, si_s2;
   logic [srmc_pkg::FRAME_W-1:0] sh_reg;
   logic [srmc_pkg::CNT_W-1:0] cnt_reg;
   logic so_reg, done_reg, err_reg;
   logic sclk_rise, sclk_fall, cs_fall, cs_rise;

   // Two-stage synchronisers; the third stage only serves edge detection.
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         sclk_s1 <= 1'b0;
         sclk_s2 <= 1'b0;
         sclk_s3 <= 1'b0;
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
         cs_s3 <= 1'b1;
         si_s1 <= 1'b0;
         si_s2 <= 1'b0;
      end else begin
         sclk_s1 <= sclk_i;
         sclk_s2 <= sclk_s1;
         sclk_s3 <= sclk_s2;
         cs_s1 <= cs_n_i;
         cs_s2 <= cs_s1;
         cs_s3 <= cs_s2;
         si_s1 <= si_i;
         si_s2 <= si_s1;
      end
   end

   assign sclk_rise = sclk_s2 & ~sclk_s3;
   assign sclk_fall = ~sclk_s2 & sclk_s3;
   assign cs_fall = ~cs_s2 & cs_s3;
   assign cs_rise = cs_s2 & ~cs_s3;

   // Plain shift register: bits beyond one frame pass from input to output,
   // which gives daisy-chain pass-through without any extra logic.
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         sh_reg <= '0;
         cnt_reg <= '0;
         so_reg <= 1'b0;
      end else if (cs_fall) begin
         sh_reg <= tx_i;
         cnt_reg <= '0;
         so_reg <= tx_i[srmc_pkg::FRAME_W-1];
      end else if (!cs_s2) begin
         if (sclk_rise) begin
            sh_reg <= {sh_reg[srmc_pkg::FRAME_W-2:0], si_s2};
            if (cnt_reg != '1) begin
               cnt_reg <= cnt_reg + 1'b1;
            end
         end else if (sclk_fall) begin
            so_reg <= sh_reg[srmc_pkg::FRAME_W-1];
         end
      end
   end

   // A frame is good only with a whole, non-zero number of words; a saturated
   // count is odd and therefore reported as an error.
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         done_reg <= 1'b0;
         err_reg <= 1'b0;
      end else begin
         done_reg <= cs_rise && (cnt_reg != '0) && (cnt_reg[2:0] == 3'h0);
         err_reg <= cs_rise && !((cnt_reg != '0) && (cnt_reg[2:0] == 3'h0));
      end
   end

   assign rx_o = sh_reg;
   assign done_o = done_reg;
   assign err_o = err_reg;
   assign so_o = so_reg;
   assign so_oe_o = ~cs_s2;

endmodule

`default_nettype wire

// File: src/srmc_supply_reset_ctrl.sv
// Contract
// - Logic supply start-up resets all serial registers.
// - Serial port and daisy chain run in every mode once the wake-up time has ended.
// - First frame after reset: channel readback, error.
// - Selector code 111 enters stand-by immediately.
// - Stand-by entry clears thermal fault latches.
// - Stand-by entry sets readable stand-by flag.
// - Idle: channels off, awake, supply present. The code tests selector not 111 for awake, so limp-home never shows idle.
// - Limp-home input wakes device without supply.
// - Resets restore registers; power-on reset clears stages unless limp-home.
// - Release reset; host waits wake-up time.
// - Software reset bit restores registers like power-on reset, but does not restart the wake-up time.
// - Limp-home holds writable registers at reset.
// - Limp-home stages follow only input pins.
// - Limp-home serves reads, discards all writes.
// - Current sense disabled in limp-home.
// - Config bit 1: stand-by read, reset write.
`timescale 1ns/1ps
`default_nettype none

module srmc_supply_reset_ctrl #(
   parameter int WU_CYCLES = srmc_pkg::WU_CYC
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic si_i,
   output logic so_o,
   output logic so_oe_o,
   input wire logic limp_home_input_i,
   input wire logic [srmc_pkg::N_CH-1:0] channel_input_pin_i,
   output logic [srmc_pkg::N_CH-1:0] channel_power_stage_o,
   output logic [2:0] sense_selector_o,
   output logic sense_enable_o,
   output logic standby_flag_o,
   output logic thermal_clear_o,
   output logic idle_o,
   output logic limp_active_o,
   output logic spi_ready_o
);

   localparam int WU_W = $clog2(WU_CYCLES + 1);

   srmc_pkg::srmc_state_t state_reg;
   srmc_pkg::srmc_frame_t rx_frame;
   srmc_pkg::srmc_reply_t tx_reply;
   logic [srmc_pkg::FRAME_W-1:0] rx_word;
   logic [WU_W-1:0] wu_cnt_reg;
   logic [srmc_pkg::N_CH-1:0] out_reg, stage_reg, in_s1, in_s2;
   logic [2:0] sel_reg;
   logic [1:0] rd_addr_reg;
   logic limp_s1, limp_s2;
   logic first_reg, ter_reg, rst_pend_reg;
   logic standby_reg, standby_next, therm_reg, idle_reg, sense_en_reg;
   logic done, err, fr_end, sh_oe, wr_ok, soft_rst;

   // Readback of the addressed register.
   function automatic logic [4:0] read_mux(input logic [1:0] addr, input logic [4:0] outv,
                                           input logic [2:0] sel, input logic stb,
                                           input logic limp);
      logic [4:0] v;
      v = '0;
      unique case (addr)
         srmc_pkg::ADDR_OUT: v = outv;
         srmc_pkg::ADDR_DCR: v = {2'h0, sel};
         srmc_pkg::ADDR_HARDWARE_CONFIG_REGISTER: begin
            v[srmc_pkg::HW_STB_BIT] = stb;
            v[srmc_pkg::HW_LHI_BIT] = limp;
         end
         default: v = '0;
      endcase
      return v;
   endfunction

   // Pins from outside the clock domain pass two flip-flops. The chain has no reset,
   // so a limp-home level still reaches the power stages while the logic is held.
   always_ff @(posedge sys_clk_i) begin
      limp_s1 <= limp_home_input_i;
      limp_s2 <= limp_s1;
      in_s1 <= channel_input_pin_i;
      in_s2 <= in_s1;
   end

   srmc_spi_shift u_shift (
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .sclk_i(sclk_i),
      .cs_n_i(cs_n_i),
      .si_i(si_i),
      .tx_i(tx_reply),
      .rx_o(rx_word),
      .done_o(done),
      .err_o(err),
      .so_o(so_o),
      .so_oe_o(sh_oe)
   );

   assign rx_frame = rx_word;
   assign fr_end = (done | err) && (state_reg == srmc_pkg::SRMC_RUN);
   assign wr_ok = done && rx_frame.wr && !limp_s2 && (state_reg == srmc_pkg::SRMC_RUN);
   assign soft_rst = rst_pend_reg;

   // Reply word: the first one after any reset is forced to channel readback
   // with the error flag raised, so the host can spot the reset.
   always_comb begin
      if (first_reg) begin
         tx_reply.transfer_error_flag = 1'b1;
         tx_reply.addr = srmc_pkg::ADDR_OUT;
         tx_reply.data = out_reg;
      end else begin
         tx_reply.transfer_error_flag = ter_reg;
         tx_reply.addr = rd_addr_reg;
         tx_reply.data = read_mux(rd_addr_reg, out_reg, sel_reg, standby_reg, limp_s2);
      end
   end

   // Wake-up timer after power-on reset; replies stay off the line meanwhile.
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         state_reg <= srmc_pkg::SRMC_WAKE;
         wu_cnt_reg <= '0;
      end else begin
         unique case (state_reg)
            srmc_pkg::SRMC_WAKE: begin
               if (wu_cnt_reg == WU_W'(WU_CYCLES - 1)) begin
                  state_reg <= srmc_pkg::SRMC_RUN;
               end
               wu_cnt_reg <= wu_cnt_reg + 1'b1;
            end
            srmc_pkg::SRMC_RUN: state_reg <= srmc_pkg::SRMC_RUN;
            default: state_reg <= srmc_pkg::SRMC_WAKE;
         endcase
      end
   end

   // Writable register bank. Power-on, software reset and limp-home all bring
   // it back to defaults; in limp-home every write is dropped.
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i || soft_rst || limp_s2) begin
         out_reg <= srmc_pkg::OUT_RST;
         sel_reg <= srmc_pkg::SEL_STANDBY;
      end else if (wr_ok) begin
         if (rx_frame.addr == srmc_pkg::ADDR_OUT) begin
            out_reg <= rx_frame.data;
         end
         if (rx_frame.addr == srmc_pkg::ADDR_DCR) begin
            sel_reg <= rx_frame.data[2:0];
         end
      end
   end

   // Software reset command: latched once the deselect has ended its own frame and
   // carried out one cycle later, so that transfer completes cleanly and the very
   // next frame already carries the first-frame reply.
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i || soft_rst) begin
         rst_pend_reg <= 1'b0;
      end else if (wr_ok && rx_frame.addr == srmc_pkg::ADDR_HARDWARE_CONFIG_REGISTER
                   && rx_frame.data[srmc_pkg::HW_RST_BIT]) begin
         rst_pend_reg <= 1'b1;
      end
   end

   // Reply bookkeeping. A bad frame raises the error flag; that event wins
   // over the clearing that a delivered reply otherwise causes.
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i || soft_rst) begin
         first_reg <= 1'b1;
         ter_reg <= 1'b0;
         rd_addr_reg <= srmc_pkg::ADDR_RST;
      end else if (fr_end) begin
         first_reg <= 1'b0;
         ter_reg <= err;
         if (done) begin
            rd_addr_reg <= rx_frame.addr;
         end
      end
   end

   // Stand-by follows the selector at once, regardless of the input pins;
   // a limp-home level keeps the device awake.
   assign standby_next = (sel_reg == srmc_pkg::SEL_STANDBY) && !limp_s2;

   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         standby_reg <= 1'b0;
         therm_reg <= 1'b0;
         idle_reg <= 1'b0;
         sense_en_reg <= 1'b0;
      end else begin
         standby_reg <= standby_next;
         therm_reg <= standby_next && !standby_reg;
         idle_reg <= (stage_reg == '0) && (sel_reg != srmc_pkg::SEL_STANDBY);
         sense_en_reg <= !standby_next && !limp_s2;
      end
   end

   // Power stages. Power-on reset clears them unless limp-home is active; without logic supply
   // only a limp-home level lets the pins drive them.
   always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         stage_reg <= limp_s2 ? in_s2 : '0;
      end else if (limp_s2) begin
         stage_reg <= in_s2;
      end else begin
         stage_reg <= out_reg | in_s2;
      end
   end

   assign so_oe_o = sh_oe && (state_reg == srmc_pkg::SRMC_RUN);
   assign channel_power_stage_o = stage_reg;
   assign sense_selector_o = sel_reg;
   assign sense_enable_o = sense_en_reg;
   assign standby_flag_o = standby_reg;
   assign thermal_clear_o = therm_reg;
   assign idle_o = idle_reg;
   assign limp_active_o = limp_s2;
   assign spi_ready_o = (state_reg == srmc_pkg::SRMC_RUN);

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);

   a_first_frame_reply: assert property (
      first_reg |-> tx_reply.transfer_error_flag && tx_reply.addr == srmc_pkg::ADDR_OUT)
      else $error("first reply lacks error flag or channel readback");
   a_standby_entry: assert property (
      (sel_reg == srmc_pkg::SEL_STANDBY && !limp_s2) |=> standby_flag_o)
      else $error("stand-by not entered on default selector");
   a_thermal_clear: assert property (
      $rose(standby_reg) |-> thermal_clear_o ##1 !thermal_clear_o)
      else $error("thermal clear pulse missing on stand-by entry");
   a_stb_readback: assert property (
      (!first_reg && rd_addr_reg == srmc_pkg::ADDR_HARDWARE_CONFIG_REGISTER)
      |-> tx_reply.data[srmc_pkg::HW_STB_BIT] == standby_reg)
      else $error("stand-by flag readback wrong");
   a_idle_cond: assert property (
      $rose(idle_o) |-> $past(stage_reg == '0 && sel_reg != srmc_pkg::SEL_STANDBY))
      else $error("idle raised without its condition");
   a_limp_stage: assert property (limp_s2 |=> channel_power_stage_o == $past(in_s2))
      else $error("limp-home stage does not follow pin");
   a_limp_regs: assert property (
      limp_s2 |=> out_reg == srmc_pkg::OUT_RST && sel_reg == srmc_pkg::SEL_STANDBY)
      else $error("register bank not held in limp-home");
   a_limp_sense: assert property (limp_s2 |=> !sense_enable_o)
      else $error("current sense active in limp-home");
   a_wake_quiet: assert property (
      state_reg == srmc_pkg::SRMC_WAKE |-> !so_oe_o && !spi_ready_o)
      else $error("serial output driven during wake-up");
   a_soft_reset: assert property (
      soft_rst |=> first_reg && !rst_pend_reg && out_reg == srmc_pkg::OUT_RST)
      else $error("software reset did not restore defaults");
   a_reset_at_end: assert property (rst_pend_reg |-> $past(fr_end) ##1 !rst_pend_reg)
      else $error("software reset not tied to the end of its frame");

   c_first_frame: cover property (first_reg ##1 fr_end);
   c_standby: cover property ($rose(standby_flag_o));
   c_soft_reset: cover property (soft_rst);
   c_limp: cover property ($rose(limp_active_o));

endmodule

`default_nettype wire

// File: sim/srmc_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module srmc_host_model (
   input wire logic sys_clk_i,
   input wire logic so_i,
   output logic sclk_o,
   output logic cs_n_o,
   output logic si_o,
   output logic [15:0] reply_o,
   output logic reply_v_o
);
   // The link clock idles low and only toggles inside a frame.
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      si_o = 1'b0;
      reply_o = 16'h0000;
      reply_v_o = 1'b0;
   end

   // One frame of nb bits, first bit first; hp is the half period in system cycles.
   // The serial output is sampled at a falling system edge so it never races its update.
   task automatic xfer(input logic [15:0] d, input int nb, input int hp);
      logic [15:0] r;
      r = 16'h0000;
      @(posedge sys_clk_i);
      cs_n_o <= 1'b0;
      si_o <= d[nb-1];
      for (int i = nb - 1; i >= 0; i--) begin
         repeat (hp - 1) @(posedge sys_clk_i);
         @(negedge sys_clk_i);
         r = {r[14:0], so_i};
         @(posedge sys_clk_i);
         sclk_o <= 1'b1;
         repeat (hp) @(posedge sys_clk_i);
         sclk_o <= 1'b0;
         si_o <= (i > 0) ? d[i-1] : ~si_o; // Data line shows no stale bit once released.
      end
      repeat (hp) @(posedge sys_clk_i);
      cs_n_o <= 1'b1;
      reply_o <= r;
      reply_v_o <= 1'b1;
      @(posedge sys_clk_i);
      reply_v_o <= 1'b0;
      repeat (6) @(posedge sys_clk_i); // Deselect gap well above the minimum of 4 cycles.
   endtask
endmodule

`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
   localparam int WU = 20;
   logic sys_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic limp = 1'b0;
   logic [4:0] pins = 5'h00;
   logic sclk, cs_n, si, so, so_oe, rv, tclr, sen, stb, idle, lact, rdy;
   logic [15:0] rdata;
   logic [4:0] stage;
   logic [2:0] sel;
   int mismatches = 0;
   int tests_run = 0;
   int tclr_cnt = 0;
   int oe_cnt = 0;
   logic [31:0] exp_q[$];

   // Free-running system clock at 20 MHz.
   always #25 sys_clk_i = ~sys_clk_i;

   srmc_supply_reset_ctrl #(.WU_CYCLES(WU)) DUT (
      .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .sclk_i(sclk), .cs_n_i(cs_n), .si_i(si),
      .so_o(so), .so_oe_o(so_oe), .limp_home_input_i(limp), .channel_input_pin_i(pins),
      .channel_power_stage_o(stage), .sense_selector_o(sel), .sense_enable_o(sen),
      .standby_flag_o(stb), .thermal_clear_o(tclr), .idle_o(idle),
      .limp_active_o(lact), .spi_ready_o(rdy)
   );

   srmc_host_model host (
      .sys_clk_i(sys_clk_i), .so_i(so), .sclk_o(sclk), .cs_n_o(cs_n), .si_o(si),
      .reply_o(rdata), .reply_v_o(rv)
   );

   task automatic results;
      if (exp_q.size() != 0) begin
         mismatches++;
         $display("BAD %0t %0d replies never arrived", $time, exp_q.size());
      end
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic check_reply(input logic [15:0] got, input logic [31:0] note);
      tests_run++;
      if ((got & note[31:16]) !== (note[15:0] & note[31:16])) begin
         mismatches++;
         $display("BAD %0t reply %h expected %h", $time, got, note[15:0]);
      end
   endtask

   task automatic check_sig(input logic [7:0] got, input logic [7:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t %s is %h expected %h", $time, what, got, exp);
      end
   endtask

   // Notes the expected reply, with a mask of the bits that are known, then sends the frame.
   task automatic frame(input logic [15:0] d, input int nb, input int hp,
                        input logic [15:0] e, input logic [15:0] m);
      exp_q.push_back({m, e});
      host.xfer(d, nb, hp);
   endtask

   // Bounded wait for the end of the wake-up time; a hang ends the run.
   // The ready flag is looked at on the falling edge, where it has settled.
   task automatic wait_ready(output int n);
      n = 0;
      while (rdy !== 1'b1 && n < 200) begin
         @(negedge sys_clk_i);
         n++;
      end
      if (rdy !== 1'b1) begin
         mismatches++;
         $display("BAD %0t ready never rose", $time);
         results();
      end
   endtask

   // Each reply the host collects is matched against the oldest note.
   always @(posedge sys_clk_i) begin
      if (rv === 1'b1) begin
         if (exp_q.size() == 0) begin
            mismatches++;
            $display("BAD %0t reply without expectation", $time);
         end else begin
            check_reply(rdata, exp_q.pop_front());
         end
      end
   end

   // Counts stand-by entry pulses so a missing or doubled pulse shows up.
   always @(posedge sys_clk_i) begin
      if (tclr === 1'b1) begin
         tclr_cnt++;
      end
   end

   // Counts cycles with the serial output enabled, sampled where it has settled.
   always @(negedge sys_clk_i) begin
      if (so_oe === 1'b1) begin
         oe_cnt++;
      end
   end

   initial begin
      int n;
      n = $urandom(32'h908f);
      repeat (5) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      check_sig(8'(rdy), 8'h00, "ready in reset");
      check_sig(8'(sel), 8'h07, "selector in reset");
      @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      wait_ready(n);
      check_sig(8'(n >= WU && n <= WU + 2), 8'h01, "wake-up time");
      @(negedge sys_clk_i);
      check_sig(8'(stb), 8'h01, "stand-by flag");
      check_sig(8'(sen), 8'h00, "sense in stand-by");
      check_sig(8'(tclr_cnt), 8'h01, "thermal clear");
      $display("test power-on done");
      frame(16'h0000, 8, 4, 16'h0080, 16'h00ff);
      frame(16'h00a0, 8, 4, 16'h0000, 16'h00ff);
      @(negedge sys_clk_i);
      check_sig(8'(sel), 8'h00, "selector");
      check_sig(8'(stb), 8'h00, "awake flag");
      check_sig(8'(sen), 8'h01, "sense awake");
      check_sig(8'(idle), 8'h01, "idle");
      $display("test wake done");
      @(posedge sys_clk_i);
      pins <= 5'($urandom);
      frame(16'h0095, 8, 4, 16'h0020, 16'h00ff);
      @(negedge sys_clk_i);
      check_sig(8'(stage), 8'(5'h15 | pins), "stages");
      check_sig(8'(idle), 8'h00, "not idle");
      frame(16'h5a00, 16, 4, 16'h005a, 16'he0ff);
      frame(16'h0005, 4, 4, 16'h0001, 16'h000f);
      frame(16'h0000, 8, 4, 16'h0095, 16'h00ff);
      $display("test channels and chain done");
      @(posedge sys_clk_i);
      limp <= 1'b1;
      pins <= 5'($urandom);
      repeat (4) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      check_sig(8'(lact), 8'h01, "limp active");
      check_sig(8'(sen), 8'h00, "sense in limp");
      check_sig(8'(sel), 8'h07, "selector in limp");
      check_sig(8'(stage), 8'(pins), "limp stages");
      frame(16'h009f, 8, 4, 16'h0000, 16'h00e0);
      frame(16'h0040, 8, 4, 16'h0000, 16'h00ff);
      frame(16'h0000, 8, 4, 16'h0044, 16'h00fd);
      @(negedge sys_clk_i);
      check_sig(8'(stage), 8'(pins), "limp stages after write");
      @(posedge sys_clk_i);
      limp <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      check_sig(8'(tclr_cnt), 8'h02, "thermal clear after limp");
      $display("test limp-home done");
      frame(16'h00a0, 8, 4, 16'h0000, 16'h00ff);
      frame(16'h0083, 8, 4, 16'h0020, 16'h00ff);
      frame(16'h00c2, 8, 4, 16'h0003, 16'h00ff);
      @(negedge sys_clk_i);
      check_sig(8'(sel), 8'h07, "selector at frame end");
      frame(16'h0040, 8, 4, 16'h0080, 16'h00ff);
      wait_ready(n);
      repeat (10) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      check_sig(8'(sel), 8'h07, "selector after soft reset");
      check_sig(8'(stb), 8'h01, "stand-by after soft reset");
      check_sig(8'(tclr_cnt), 8'h03, "thermal clear after soft reset");
      frame(16'h0000, 8, 4, 16'h0042, 16'h00ff);
      check_sig(8'(oe_cnt != 0), 8'h01, "serial output enabled");
      $display("test software reset done");
      results();
   end
endmodule

`default_nettype wire
